// file: rtl/spj_edge_det.sv
// edge detection and sticky flags with write-one-to-clear
// assumes pin levels already synchronised
`include "spj_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spj_edge_det (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] pin_sync,
    input wire logic [7:0] polarity,
    input wire logic [7:0] clear_mask,
    output logic [7:0] flags
);
    logic [7:0] prev_reg;
    logic [7:0] flags_reg;
    logic [7:0] active;
    // polarity 0 falling, 1 rising
    assign active = `SPJ_IMPL_MASK & ((polarity & pin_sync & ~prev_reg) |
        (~polarity & ~pin_sync & prev_reg));
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_reg <= `SPJ_RST_PULL_EN;
        end else begin
            prev_reg <= pin_sync;
        end
    end
    // set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= `SPJ_RST_ZERO;
        end else begin
            flags_reg <= (flags_reg & ~clear_mask) | active;
        end
    end
    assign flags = flags_reg;
endmodule : spj_edge_det
`default_nettype wire

// file: rtl/spj_pin_mux.sv
// per-pin ownership, direction and pull logic for the four port pins
// assumes peripheral enables are synchronous to SYS_CLK
`include "spj_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spj_pin_mux (
    input wire logic rst,
    input wire spj_pkg::spj_periph_t periph,
    input wire logic [7:0] out_data,
    input wire logic [7:0] direction,
    input wire logic [7:0] drive,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] polarity,
    output logic [7:0] dout,
    output logic [7:0] oe,
    output logic [7:0] reduced,
    output logic [7:0] pull_on,
    output logic [7:0] pull_up
);
    import spj_pkg::*;
    // a macro literal cannot be bit-selected, so give the mask a name
    localparam logic [7:0] IMPL_MASK = `SPJ_IMPL_MASK;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            logic can_own, i2c_own, is_out, od, drv, lvl;
            logic i2c_low;
            if (i == `SPJ_BIT_I2C_SCL) begin : g_scl
                assign i2c_low = periph.i2c_scl_low;
            end else begin : g_sda
                assign i2c_low = periph.i2c_sda_low;
            end
            assign can_own = periph.can_en &&
                (i == `SPJ_BIT_CAN_TX || i == `SPJ_BIT_CAN_RX);
            assign i2c_own = !can_own && periph.i2c_en &&
                (i == `SPJ_BIT_I2C_SCL || i == `SPJ_BIT_I2C_SDA);
            // open drain: enable only while pulling low
            assign od = i2c_own;
            always_comb begin
                is_out = 1'b0;
                lvl = 1'b0;
                if (rst || !IMPL_MASK[i]) begin
                    is_out = 1'b0;
                end else if (can_own) begin
                    is_out = (i == `SPJ_BIT_CAN_TX);
                    lvl = periph.can_tx;
                end else if (i2c_own) begin
                    is_out = i2c_low;
                    lvl = 1'b0;
                end else begin
                    is_out = direction[i];
                    lvl = out_data[i];
                end
            end
            assign drv = is_out;
            assign dout[i] = lvl;
            assign oe[i] = drv;
            assign reduced[i] = drv && !od && !rst && drive[i];
            // pull only for inputs or wired-or, never push-pull
            always_comb begin
                if (!IMPL_MASK[i]) begin
                    pull_on[i] = 1'b0;
                    pull_up[i] = 1'b0;
                end else if (rst) begin
                    pull_on[i] = 1'b1;
                    pull_up[i] = 1'b1;
                end else begin
                    pull_on[i] = pull_en[i] &&
                        (od || !drv);
                    // pull-down only for a plain input
                    pull_up[i] = !polarity[i] || od;
                end
            end
        end
    endgenerate
endmodule : spj_pin_mux
`default_nettype wire

// file: rtl/spj_pkg.sv
// types shared by the shared port j block
// assumes spj_regs.svh for numeric constants
package spj_pkg;
    typedef struct packed {
        logic [7:0] din;
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] reduced;
        logic [7:0] pull_on;
        logic [7:0] pull_up;
    } spj_pins_t;
    typedef struct packed {
        logic can_en;
        logic can_tx;
        logic i2c_en;
        logic i2c_scl_low;
        logic i2c_sda_low;
    } spj_periph_t;
    typedef enum logic [2:0] {
        SPJ_W_IDLE = 3'b001,
        SPJ_W_RESP = 3'b010,
        SPJ_W_HOLD = 3'b100
    } spj_wstate_t;
endpackage : spj_pkg

// file: rtl/spj_port.sv
// shared port j: four-pin gpio shared with can and i2c, axi4-lite slave
// assumes one clock, synchronous active-high reset, pins as three signals
`include "spj_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spj_port (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire spj_pkg::spj_periph_t PERIPH,
    output logic CAN_RX,
    output logic I2C_SCL_IN,
    output logic I2C_SDA_IN,
    input wire logic [7:0] PIN_IN,
    output spj_pkg::spj_pins_t PIN_CTRL,
    output logic IRQ
);
    import spj_pkg::*;
    logic [7:0] out_data_reg, direction_reg, drive_reg, pull_en_reg;
    logic [7:0] polarity_reg, irq_en_reg;
    logic [1:0] periph_en_reg;
    logic [7:0] sync1_reg, sync2_reg;
    logic [7:0] flags, clear_mask;
    logic [7:0] dout, oe, reduced, pull_on, pull_up;
    spj_periph_t periph_eff;
    logic aw_got_reg, w_got_reg;
    logic [5:0] aw_idx_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    spj_wstate_t wstate_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_fire, wr_ok;
    logic [7:0] wbyte;
    logic [5:0] ar_idx;
    logic [7:0] rbyte;
    logic r_ok;

    // peripheral enables are software bits gated with the controllers' own
    always_comb begin
        periph_eff = PERIPH;
        periph_eff.can_en = PERIPH.can_en && periph_en_reg[`SPJ_EN_CAN];
        periph_eff.i2c_en = PERIPH.i2c_en && periph_en_reg[`SPJ_EN_I2C];
    end

    spj_pin_mux u_mux (
        .rst(RST),
        .periph(periph_eff),
        .out_data(out_data_reg),
        .direction(direction_reg),
        .drive(drive_reg),
        .pull_en(pull_en_reg),
        .polarity(polarity_reg),
        .dout(dout),
        .oe(oe),
        .reduced(reduced),
        .pull_on(pull_on),
        .pull_up(pull_up)
    );

    // two-stage sync costs two cycles of read latency
    // reset to the pulled-up idle level, else a false edge follows reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sync1_reg <= `SPJ_RST_PULL_EN;
            sync2_reg <= `SPJ_RST_PULL_EN;
        end else begin
            sync1_reg <= PIN_IN;
            sync2_reg <= sync1_reg;
        end
    end

    spj_edge_det u_edge (
        .clk(SYS_CLK),
        .rst(RST),
        .pin_sync(sync2_reg),
        .polarity(polarity_reg),
        .clear_mask(clear_mask),
        .flags(flags)
    );

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PIN_CTRL.din <= `SPJ_RST_ZERO;
            PIN_CTRL.dout <= `SPJ_RST_ZERO;
            PIN_CTRL.oe <= `SPJ_RST_ZERO;
            PIN_CTRL.reduced <= `SPJ_RST_ZERO;
            PIN_CTRL.pull_on <= `SPJ_RST_PULL_EN;
            PIN_CTRL.pull_up <= `SPJ_RST_PULL_EN;
            CAN_RX <= 1'b1;
            I2C_SCL_IN <= 1'b1;
            I2C_SDA_IN <= 1'b1;
        end else begin
            PIN_CTRL.din <= sync2_reg & `SPJ_IMPL_MASK;
            PIN_CTRL.dout <= dout;
            PIN_CTRL.oe <= oe;
            PIN_CTRL.reduced <= reduced;
            PIN_CTRL.pull_on <= pull_on;
            PIN_CTRL.pull_up <= pull_up;
            CAN_RX <= sync2_reg[`SPJ_BIT_CAN_RX];
            I2C_SCL_IN <= sync2_reg[`SPJ_BIT_I2C_SCL];
            I2C_SDA_IN <= sync2_reg[`SPJ_BIT_I2C_SDA];
        end
    end

    assign IRQ = |(flags & irq_en_reg);

    // write path: address and data taken in either order
    assign S_AXI_AWREADY = !aw_got_reg && (wstate_reg == SPJ_W_IDLE);
    assign S_AXI_WREADY = !w_got_reg && (wstate_reg == SPJ_W_IDLE);
    assign wr_fire = aw_got_reg && w_got_reg && (wstate_reg == SPJ_W_IDLE);
    assign wbyte = w_data_reg[7:0] & `SPJ_IMPL_MASK;
    always_comb begin
        case (aw_idx_reg)
            `SPJ_IDX_OUT_DATA, `SPJ_IDX_PIN_INPUT, `SPJ_IDX_DIRECTION,
            `SPJ_IDX_DRIVE, `SPJ_IDX_PULL_EN, `SPJ_IDX_POLARITY,
            `SPJ_IDX_IRQ_EN, `SPJ_IDX_EDGE_FLAGS,
            `SPJ_IDX_PERIPH_EN: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end
    assign clear_mask = (wr_fire && w_strb_reg[0] &&
        aw_idx_reg == `SPJ_IDX_EDGE_FLAGS) ? wbyte : 8'h00;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_idx_reg <= 6'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_reg <= 1'b1;
                aw_idx_reg <= S_AXI_AWADDR[7:2];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            wstate_reg <= SPJ_W_IDLE;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SPJ_RESP_OKAY;
        end else begin
            case (wstate_reg)
                SPJ_W_IDLE: begin
                    if (wr_fire) begin
                        bvalid_reg <= 1'b1;
                        bresp_reg <= wr_ok ? `SPJ_RESP_OKAY : `SPJ_RESP_SLVERR;
                        wstate_reg <= SPJ_W_RESP;
                    end
                end
                SPJ_W_RESP: begin
                    if (S_AXI_BREADY) begin
                        bvalid_reg <= 1'b0;
                        wstate_reg <= SPJ_W_HOLD;
                    end
                end
                SPJ_W_HOLD: begin
                    wstate_reg <= SPJ_W_IDLE;
                end
                default: begin
                    wstate_reg <= SPJ_W_IDLE;
                    bvalid_reg <= 1'b0;
                end
            endcase
        end
    end
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;

    // register file, byte lane 0 only
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            out_data_reg <= `SPJ_RST_ZERO;
            direction_reg <= `SPJ_RST_ZERO;
            drive_reg <= `SPJ_RST_ZERO;
            pull_en_reg <= `SPJ_RST_PULL_EN;
            polarity_reg <= `SPJ_RST_ZERO;
            irq_en_reg <= `SPJ_RST_ZERO;
            periph_en_reg <= 2'h0;
        end else if (wr_fire && w_strb_reg[0]) begin
            case (aw_idx_reg)
                `SPJ_IDX_OUT_DATA: out_data_reg <= wbyte;
                `SPJ_IDX_DIRECTION: direction_reg <= wbyte;
                `SPJ_IDX_DRIVE: drive_reg <= wbyte;
                `SPJ_IDX_PULL_EN: pull_en_reg <= wbyte;
                `SPJ_IDX_POLARITY: polarity_reg <= wbyte;
                `SPJ_IDX_IRQ_EN: irq_en_reg <= wbyte;
                `SPJ_IDX_PERIPH_EN: periph_en_reg <= w_data_reg[1:0];
                default: out_data_reg <= out_data_reg;
            endcase
        end
    end

    // read path, one outstanding read
    assign S_AXI_ARREADY = !rvalid_reg;
    assign ar_idx = S_AXI_ARADDR[7:2];
    always_comb begin
        r_ok = 1'b1;
        case (ar_idx)
            `SPJ_IDX_OUT_DATA: rbyte = (direction_reg & out_data_reg) |
                (~direction_reg & sync2_reg);
            `SPJ_IDX_PIN_INPUT: rbyte = sync2_reg;
            `SPJ_IDX_DIRECTION: rbyte = direction_reg;
            `SPJ_IDX_DRIVE: rbyte = drive_reg;
            `SPJ_IDX_PULL_EN: rbyte = pull_en_reg;
            `SPJ_IDX_POLARITY: rbyte = polarity_reg;
            `SPJ_IDX_IRQ_EN: rbyte = irq_en_reg;
            `SPJ_IDX_EDGE_FLAGS: rbyte = flags;
            `SPJ_IDX_PERIPH_EN: rbyte = {6'h00, periph_en_reg};
            default: begin
                rbyte = 8'h00;
                r_ok = 1'b0;
            end
        endcase
    end
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SPJ_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, ar_idx == `SPJ_IDX_PERIPH_EN ? rbyte :
                (rbyte & `SPJ_IMPL_MASK)};
            rresp_reg <= r_ok ? `SPJ_RESP_OKAY : `SPJ_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
endmodule : spj_port
`default_nettype wire

// file: rtl/spj_regs.svh
// register offsets, field positions and reset values of the shared port
// assumes a 32-bit AXI4-Lite slave, one register per aligned word
`ifndef SPJ_REGS_SVH
`define SPJ_REGS_SVH
`define SPJ_IDX_OUT_DATA 6'h28
`define SPJ_IDX_PIN_INPUT 6'h29
`define SPJ_IDX_DIRECTION 6'h2A
`define SPJ_IDX_DRIVE 6'h2B
`define SPJ_IDX_PULL_EN 6'h2C
`define SPJ_IDX_POLARITY 6'h2D
`define SPJ_IDX_IRQ_EN 6'h2E
`define SPJ_IDX_EDGE_FLAGS 6'h2F
`define SPJ_IDX_PERIPH_EN 6'h30
`define SPJ_IMPL_MASK 8'hC3
`define SPJ_RST_ZERO 8'h00
`define SPJ_RST_PULL_EN 8'hC3
`define SPJ_BIT_CAN_TX 7
`define SPJ_BIT_CAN_RX 6
`define SPJ_BIT_I2C_SCL 1
`define SPJ_BIT_I2C_SDA 0
`define SPJ_EN_CAN 0
`define SPJ_EN_I2C 1
`define SPJ_RESP_OKAY 2'h0
`define SPJ_RESP_SLVERR 2'h2
`endif

// file: verification/spj_pin_model.sv
// far side of the shared port pins: outside drivers and pull devices
// assumes the bench drives only pins that the device leaves undriven
`timescale 1ns/1ps
`default_nettype none
module spj_pin_model (
    input wire logic clk,
    input wire spj_pkg::spj_pins_t ctrl,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin
);
    import spj_pkg::*;
    logic [7:0] last_reg = 8'h00;
    // a floating pin flips each cycle so a stale level never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ctrl.oe[i]) pin[i] = ctrl.dout[i];
            else if (ext_en[i]) pin[i] = ext_val[i];
            else if (ctrl.pull_on[i]) pin[i] = ctrl.pull_up[i];
            else pin[i] = ~last_reg[i];
        end
    end
    always_ff @(posedge clk) begin
        last_reg <= pin;
    end
endmodule : spj_pin_model
`default_nettype wire

// file: verification/spj_port_props.sv
// checker on the shared port top-level ports: reset state, bus, pins, irq
// assumes it is bound to spj_port and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module spj_port_props (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    input wire spj_pkg::spj_periph_t PERIPH,
    input wire logic CAN_RX,
    input wire logic I2C_SCL_IN,
    input wire logic I2C_SDA_IN,
    input wire spj_pkg::spj_pins_t PIN_CTRL,
    input wire logic IRQ
);
    import spj_pkg::*;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    sequence s_wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    // a register write lands on the same edge that first raises its response
    sequence s_wr_done;
        $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2);
    endsequence
    sequence s_b_gap;
        !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_AWREADY && S_AXI_WREADY;
    endsequence
    property p_rst_hold;
        disable iff (1'b0) RST |=> PIN_CTRL.oe == 8'h00 && CAN_RX
            && I2C_SCL_IN && I2C_SDA_IN && PIN_CTRL.pull_on == 8'hC3
            && PIN_CTRL.pull_up == 8'hC3;
    endproperty
    property p_rst_state;
        $fell(RST) |=> PIN_CTRL.pull_on == 8'hC3 && PIN_CTRL.pull_up == 8'hC3
            && PIN_CTRL.oe == 8'h00;
    endproperty
    property p_rsvd;
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000
            && S_AXI_RDATA[5:2] == 4'h0 && PIN_CTRL.oe[5:2] == 4'h0;
    endproperty
    property p_irq_fall;
        $fell(IRQ) |-> $rose(S_AXI_BVALID);
    endproperty
    // pin direction moves only after a register write or a controller change
    property p_oe_cause;
        $changed(PIN_CTRL.oe) |-> s_wr_done or ($past(PERIPH) != $past(PERIPH, 2));
    endproperty
    property p_reduced;
        (PIN_CTRL.reduced & ~PIN_CTRL.oe) == 8'h00;
    endproperty
    property p_pp_pull;
        !$past(PERIPH.i2c_en) |-> (PIN_CTRL.pull_on & PIN_CTRL.oe) == 8'h00;
    endproperty
    property p_wr_resp;
        s_wr_taken |-> ##2 S_AXI_BVALID;
    endproperty
    property p_rd_resp;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    property p_b_gap;
        S_AXI_BVALID && S_AXI_BREADY |=> s_b_gap;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset pin state");
    a_rst_state: assert property (p_rst_state) else $error("pull-up after reset");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    a_oe_cause: assert property (p_oe_cause) else $error("oe changed alone");
    a_reduced: assert property (p_reduced) else $error("reduced on input");
    a_pp_pull: assert property (p_pp_pull) else $error("pull on push-pull");
    a_wr_resp: assert property (p_wr_resp) else $error("no write response");
    a_rd_resp: assert property (p_rd_resp) else $error("no read response");
    a_b_gap: assert property (p_b_gap) else $error("write ready gap wrong");
endmodule : spj_port_props
bind spj_port spj_port_props u_props (.SYS_CLK(SYS_CLK), .RST(RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA), .PERIPH(PERIPH),
    .CAN_RX(CAN_RX), .I2C_SCL_IN(I2C_SCL_IN), .I2C_SDA_IN(I2C_SDA_IN),
    .PIN_CTRL(PIN_CTRL), .IRQ(IRQ));
`default_nettype wire

// file: verification/tb_shared_port_j_io_with_edge_irq.sv
// self-checking bench of the shared port: registers, pins, edges, irq
// assumes spj_port with the pin model on PIN_CTRL/PIN_IN, 40 MHz clock
`include "spj_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_shared_port_j_io_with_edge_irq;
    import spj_pkg::*;
    localparam logic [31:0] A_OUT = 32'hA0, A_PIN = 32'hA4, A_DIR = 32'hA8,
        A_DRV = 32'hAC, A_PUL = 32'hB0, A_POL = 32'hB4, A_IE = 32'hB8,
        A_FLG = 32'hBC, A_PEN = 32'hC0;
    localparam logic [7:0] REXP [9] = '{8'hC3, 8'hC3, 8'h00, 8'h00, 8'hC3,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [1:0] OK = `SPJ_RESP_OKAY;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, can_rx, scl_in, sda_in, irq;
    logic [1:0] bresp, rresp;
    spj_periph_t periph = 5'h00;
    spj_pins_t pctl;
    logic [7:0] pin, ext_en = 8'h00, ext_val = 8'h00;
    int err_total = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h39; // 57
    initial begin
        forever #12.5 clk = ~clk;
    end
    spj_port DUT (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .PERIPH(periph), .CAN_RX(can_rx),
        .I2C_SCL_IN(scl_in), .I2C_SDA_IN(sda_in), .PIN_IN(pin),
        .PIN_CTRL(pctl), .IRQ(irq));
    spj_pin_model u_pins (.clk(clk), .ctrl(pctl), .ext_en(ext_en),
        .ext_val(ext_val), .pin(pin));
    function automatic logic [7:0] xs8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs8
    // an output pin shows its latch, an input the outside level
    function automatic logic [7:0] f_lvl(input logic [7:0] dir, dv, ext);
        return ((dir & dv) | (~dir & ext)) & 8'hC3;
    endfunction : f_lvl
    function automatic logic [7:0] f_edge(input logic [7:0] o, n, pol);
        return ((~pol & o & ~n) | (pol & ~o & n)) & 8'hC3;
    endfunction : f_edge
    task give_verdict();
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 64) begin
            $display("ERROR %0t bus wait timed out", $time);
            err_total++;
            give_verdict();
        end
    endtask : tick
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %0t got %h expected %h", $time, g, e);
            err_total++;
        end
    endtask : chk_reg
    task chk_pin(input logic [7:0] g, input logic [7:0] e);
        chk_reg({24'h000000, g}, {24'h000000, e});
    endtask : chk_pin
    task chk_bit(input logic g, input logic e);
        chk_reg({31'h0, g}, {31'h0, e});
    endtask : chk_bit
    task chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk_reg({30'h0, g}, {30'h0, e});
    endtask : chk_resp
    task wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic aw_d;
        logic w_d;
        n = 0;
        aw_d = 1'b0;
        w_d = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            tick(n);
            if (!aw_d && awready === 1'b1) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_d && wready === 1'b1) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_d && w_d));
        do tick(n); while (bvalid !== 1'b1);
        // bready stays high; every call sets it again and nothing ever lowers it
        chk_resp(bresp, er);
    endtask : wr
    task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do tick(n); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask : rd
    task rchk(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk_reg(d, {24'h000000, e});
        chk_resp(r, OK);
    endtask : rchk
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] dir, dv, pol, pe, ie, drv, v0, v1, p0, fe;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        chk_pin(pctl.pull_on & pctl.pull_up & ~pctl.oe, 8'hC3);
        for (int i = 0; i < 9; i++) begin
            rchk(32'hA0 + 32'(4 * i), REXP[i]);
        end
        rd(32'hC4, d, r);
        chk_reg(d, 32'h0);
        chk_resp(r, `SPJ_RESP_SLVERR);
        wr(32'hC4, 8'hFF, `SPJ_RESP_SLVERR);
        wr(A_PIN, 8'h00, OK);
        rchk(A_PIN, 8'hC3);
        wr(A_DIR, 8'hFF, OK);
        rchk(A_DIR, 8'hC3);
        // random configurations; flags cleared before the change from v0 to v1
        for (int k = 0; k < 6; k++) begin
            dir = xs8();
            dv = xs8();
            pol = xs8();
            pe = xs8();
            ie = xs8();
            drv = xs8();
            v0 = xs8();
            v1 = xs8();
            ext_en <= ~dir & 8'hC3;
            ext_val <= v0;
            wr(A_DIR, dir, OK);
            wr(A_OUT, dv, OK);
            wr(A_POL, pol, OK);
            wr(A_PUL, pe, OK);
            wr(A_DRV, drv, OK);
            wr(A_IE, ie, OK);
            repeat (4) @(posedge clk);
            wr(A_FLG, 8'hFF, OK);
            p0 = f_lvl(dir, dv, v0);
            rchk(A_OUT, p0);
            rchk(A_PIN, p0);
            chk_pin(pctl.din, p0);
            chk_pin(pctl.oe, dir & 8'hC3);
            chk_pin(pctl.dout & pctl.oe, dir & dv & 8'hC3);
            chk_pin(pctl.reduced, drv & dir & 8'hC3);
            chk_pin(pctl.pull_on, pe & ~dir & 8'hC3);
            chk_pin(pctl.pull_on & pctl.pull_up, pe & ~dir & ~pol & 8'hC3);
            ext_val <= v1;
            repeat (4) @(posedge clk);
            fe = f_edge(p0, f_lvl(dir, dv, v1), pol);
            rchk(A_FLG, fe);
            chk_bit(irq, |(fe & ie));
        end
        wr(A_DIR, 8'h00, OK);
        wr(A_POL, 8'h00, OK);
        wr(A_IE, 8'h00, OK);
        ext_en <= 8'hC3;
        ext_val <= 8'hC3;
        repeat (4) @(posedge clk);
        wr(A_FLG, 8'hFF, OK);
        ext_val <= 8'h00;
        repeat (4) @(posedge clk);
        chk_bit(irq, 1'b0);
        wr(A_IE, 8'h01, OK);
        chk_bit(irq, 1'b1);
        wr(A_FLG, 8'h3C, OK);
        rchk(A_FLG, 8'hC3);
        wr(A_FLG, 8'h01, OK);
        rchk(A_FLG, 8'hC2);
        chk_bit(irq, 1'b0);
        // can on 7/6, i2c holding scl low and releasing sda
        ext_en <= 8'h00;
        wr(A_DIR, 8'hC3, OK);
        wr(A_OUT, 8'hC3, OK);
        wr(A_PUL, 8'hC3, OK);
        periph <= 5'h16;
        wr(A_PEN, 8'h03, OK);
        repeat (4) @(posedge clk);
        chk_pin(pctl.oe, 8'h82);
        chk_pin(pctl.dout & pctl.oe, 8'h00);
        chk_pin(pctl.pull_on & pctl.pull_up, 8'h43);
        rchk(A_OUT, 8'hC3);
        rchk(A_PIN, 8'h41);
        rchk(A_DIR, 8'hC3);
        chk_pin({5'h00, can_rx, scl_in, sda_in}, 8'h05);
        periph <= 5'h18;
        repeat (4) @(posedge clk);
        chk_pin(pctl.oe & pctl.dout, 8'h83);
        periph <= 5'h00;
        repeat (4) @(posedge clk);
        chk_pin(pctl.oe, 8'hC3);
        give_verdict();
    end
endmodule : tb_shared_port_j_io_with_edge_irq
`default_nettype wire
